// *** rtl/evt_irq_pkg.sv ***
`default_nettype none
package evt_irq_pkg;
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam int          FILL_W          = 5;
	localparam int          SEL_W           = 3;
	localparam int          NUM_EVT         = 7;
	localparam logic [11:0] OFF_TRIG_SEL    = 12'h034;
	localparam logic [11:0] OFF_MASK        = 12'h038;
	localparam logic [11:0] OFF_RAW         = 12'h03C;
	localparam logic [11:0] OFF_MASKED      = 12'h040;
	localparam logic [11:0] OFF_CLEAR       = 12'h044;
	localparam int          EVT_LSB         = 4;
	localparam int          EVT_MSB         = 10;
	localparam int          BIT_OVERRUN     = 10;
	localparam int          BIT_BREAK       = 9;
	localparam int          BIT_PARITY      = 8;
	localparam int          BIT_FRAME       = 7;
	localparam int          BIT_RX_TIMEOUT  = 6;
	localparam int          BIT_TX_LEVEL    = 5;
	localparam int          BIT_RX_LEVEL    = 4;
	localparam logic [3:0]  RAW_LOW_RESET   = 4'hF;
	localparam logic [2:0]  TRIG_SEL_RESET  = 3'h2;
	localparam int          TRIG_TX_LSB     = 0;
	localparam int          TRIG_RX_LSB     = 3;
	localparam int          TRIG_FIELD_W    = 6;

	typedef enum logic [1:0] {
		APB_IDLE   = 2'b00,
		APB_SETUP  = 2'b01,
		APB_ACCESS = 2'b11
	} apb_phase_t;

	// Trigger point in entries for a select code, 16-entry FIFO
	function automatic logic [FILL_W-1:0] trig_level(input logic [SEL_W-1:0] sel);
		case (sel)
			3'h0:    trig_level = 5'h02;
			3'h1:    trig_level = 5'h04;
			3'h2:    trig_level = 5'h08;
			3'h3:    trig_level = 5'h0C;
			3'h4:    trig_level = 5'h0E;
			default: trig_level = 5'h08;
		endcase
	endfunction : trig_level
endpackage : evt_irq_pkg
`default_nettype wire

// *** rtl/level_cross_det.sv ***
`default_nettype none
module level_cross_det
	import evt_irq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic [FILL_W-1:0] fill,
	input  wire logic [SEL_W-1:0]  sel,
	input  wire logic              rising,
	output logic                   hit
);
	logic [FILL_W-1:0] prev_r;
	logic [FILL_W-1:0] lvl;

	assign lvl = trig_level(sel);

	always_comb begin
		if (rising) begin
			hit = (prev_r < lvl) && (fill >= lvl);
		end else begin
			hit = (prev_r > lvl) && (fill <= lvl);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prev_r <= '0;
		end else if (ce) begin
			prev_r <= fill;
		end
	end
endmodule : level_cross_det
`default_nettype wire

// *** rtl/evt_irq_ctrl.sv ***
//Functional notes
// - Raw status read shows unmasked source state; writes change nothing.
// - Raw bits overrun 10 down to rx level 4, reset zero.
// - Raw bits 3:0 read-only, read as all ones.
// - Masked status read shows masked state; writes change nothing.
// - Masked bits at same positions, reset zero, bits 3:0 read zero.
// - Writing one to clear bit clears raw and masked state.
// - Writing zero to a clear bit leaves that state alone.
// - Clear bits overrun 10 down to rx level 4, write-one-to-clear.
// - Masked bit equals raw bit AND its mask bit.
// - Tx and rx level bits set on passing the trigger level.
//
// Design decision made here: the APB register port.
`default_nettype none
module evt_irq_ctrl
	import evt_irq_pkg::*;
(
	input  wire logic              CORE_CLK,
	input  wire logic              RST_B,
	input  wire logic              CLK_EN,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [DATA_W-1:0] PWDATA,
	output logic      [DATA_W-1:0] PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic              OVERRUN_EVT,
	input  wire logic              LINE_BREAK_EVT,
	input  wire logic              PARITY_FAULT_EVT,
	input  wire logic              FRAME_FAULT_EVT,
	input  wire logic              RX_TIMEOUT_EVT,
	input  wire logic [FILL_W-1:0] TX_FILL,
	input  wire logic [FILL_W-1:0] RX_FILL,
	output logic                   UART_IRQ
);
	//--------------------------------------------------------------
	// Bus decode
	//--------------------------------------------------------------
	logic                    access;
	logic                    wr_en;
	logic                    rd_en;
	logic                    mapped;
	logic [NUM_EVT-1:0]      raw_r;
	logic [NUM_EVT-1:0]      raw_nxt;
	logic [NUM_EVT-1:0]      mask_r;
	logic [NUM_EVT-1:0]      mask_nxt;
	logic [TRIG_FIELD_W-1:0] trig_r;
	logic [NUM_EVT-1:0]      set_vec;
	logic [NUM_EVT-1:0]      clr_vec;
	logic [NUM_EVT-1:0]      masked;
	logic                    tx_hit;
	logic                    rx_hit;
	logic [DATA_W-1:0]       rd_val;
	logic                    ready_r;

	assign access = PSEL && PENABLE && !ready_r && CLK_EN;
	assign wr_en  = access && PWRITE;
	assign rd_en  = access && !PWRITE;
	assign mapped = (PADDR == OFF_TRIG_SEL) || (PADDR == OFF_MASK) || (PADDR == OFF_RAW)
		|| (PADDR == OFF_MASKED) || (PADDR == OFF_CLEAR);

	//--------------------------------------------------------------
	// Level crossing
	//--------------------------------------------------------------
	level_cross_det u_tx_det (
		.clk    (CORE_CLK),
		.rst_b  (RST_B),
		.ce     (CLK_EN),
		.fill   (TX_FILL),
		.sel    (trig_r[TRIG_TX_LSB +: SEL_W]),
		.rising (1'b0),
		.hit    (tx_hit)
	);

	level_cross_det u_rx_det (
		.clk    (CORE_CLK),
		.rst_b  (RST_B),
		.ce     (CLK_EN),
		.fill   (RX_FILL),
		.sel    (trig_r[TRIG_RX_LSB +: SEL_W]),
		.rising (1'b1),
		.hit    (rx_hit)
	);

	//--------------------------------------------------------------
	// Event status
	//--------------------------------------------------------------
	// bit order from overrun down to rx level
	assign set_vec = {OVERRUN_EVT, LINE_BREAK_EVT, PARITY_FAULT_EVT, FRAME_FAULT_EVT,
		RX_TIMEOUT_EVT, tx_hit, rx_hit};

	// write-one clears, zero keeps, clear field
	assign clr_vec = (wr_en && PADDR == OFF_CLEAR) ? PWDATA[EVT_MSB:EVT_LSB] : '0;

	// Set wins over a simultaneous clear
	assign raw_nxt = (raw_r & ~clr_vec) | set_vec;

	assign masked = raw_r & mask_r;

	// Mask next value, also feeds the irq flop
	assign mask_nxt = (wr_en && PADDR == OFF_MASK) ? PWDATA[EVT_MSB:EVT_LSB] : mask_r;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			raw_r <= '0;
		end else if (CLK_EN) begin
			raw_r <= raw_nxt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			mask_r <= '0;
		end else if (CLK_EN) begin
			mask_r <= mask_nxt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			trig_r <= {TRIG_SEL_RESET, TRIG_SEL_RESET};
		end else if (wr_en && PADDR == OFF_TRIG_SEL) begin
			trig_r <= PWDATA[TRIG_FIELD_W-1:0];
		end
	end

	//--------------------------------------------------------------
	// Read mux
	//--------------------------------------------------------------
	// raw view, low nibble ones, masked view
	always_comb begin
		rd_val = '0;
		case (PADDR)
			OFF_TRIG_SEL: rd_val[TRIG_FIELD_W-1:0] = trig_r;
			OFF_MASK:     rd_val[EVT_MSB:EVT_LSB] = mask_r;
			OFF_RAW: begin
				rd_val[EVT_MSB:EVT_LSB] = raw_r;
				rd_val[EVT_LSB-1:0]     = RAW_LOW_RESET;
			end
			OFF_MASKED:   rd_val[EVT_MSB:EVT_LSB] = masked;
			default:      rd_val = '0;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			ready_r <= 1'b0;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= '0;
		end else if (CLK_EN) begin
			ready_r <= access;
			PREADY  <= access;
			PSLVERR <= access && !mapped;
			if (rd_en) begin
				PRDATA <= rd_val;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			UART_IRQ <= 1'b0;
		end else if (CLK_EN) begin
			UART_IRQ <= |(raw_nxt & mask_nxt);
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	raw_read_a: assert property (PREADY && !PWRITE && $past(PADDR) == OFF_RAW && PSEL
		|-> PRDATA[EVT_MSB:EVT_LSB] == $past(raw_r)) else $error("raw read wrong");
	low_ones_a: assert property (PREADY && !PWRITE && PADDR == OFF_RAW && PSEL
		|-> PRDATA[EVT_LSB-1:0] == RAW_LOW_RESET) else $error("raw low bits wrong");
	masked_read_a: assert property (PREADY && !PWRITE && PADDR == OFF_MASKED && PSEL
		|-> PRDATA[EVT_MSB:EVT_LSB] == $past(masked)) else $error("masked read wrong");
	masked_low_a: assert property (PREADY && !PWRITE && PADDR == OFF_MASKED && PSEL
		|-> PRDATA[EVT_LSB-1:0] == 4'h0) else $error("masked low bits not zero");
	clear_hit_a: assert property (CLK_EN && (clr_vec[0] && !set_vec[0])
		|=> !raw_r[0]) else $error("clear did not act");
	zero_keep_a: assert property (CLK_EN && !clr_vec[NUM_EVT-1] && raw_r[NUM_EVT-1]
		|=> raw_r[NUM_EVT-1]) else $error("zero write cleared bit");
	raw_wr_a: assert property (wr_en && PADDR == OFF_RAW
		|=> mask_r == $past(mask_r) && trig_r == $past(trig_r)) else $error("raw write acted");
	mask_gate_a: assert property (PREADY && !PWRITE && PADDR == OFF_MASKED && PSEL
		|-> (PRDATA[EVT_MSB:EVT_LSB] & ~$past(mask_r)) == '0) else $error("mask gate");
	irq_or_a: assert property (CLK_EN |=> UART_IRQ == |(raw_r & mask_r))
		else $error("irq mismatch");
	rx_cross_a: assert property (CLK_EN && rx_hit |=> raw_r[0])
		else $error("rx level not set");

	irq_seen_c: cover property (UART_IRQ);
	clear_seen_c: cover property (wr_en && PADDR == OFF_CLEAR && |PWDATA[EVT_MSB:EVT_LSB]);
	tx_cross_c: cover property (tx_hit);
endmodule : evt_irq_ctrl
`default_nettype wire

// *** bench/evt_src.sv ***
`default_nettype none
module evt_src
	import evt_irq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [4:0]        hit,
	input  wire logic [FILL_W-1:0] tx_lvl,
	input  wire logic [FILL_W-1:0] rx_lvl,
	output var logic  [4:0]        evt,
	output var logic  [FILL_W-1:0] tx_fill,
	output var logic  [FILL_W-1:0] rx_fill
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		evt = '0;
		tx_fill = 5'h0C;
		rx_fill = 5'h00;
	end
	// Serial engine stand-in, one cycle behind the request
	always @(posedge clk) begin
		evt <= hit;
		tx_fill <= tx_lvl;
		rx_fill <= rx_lvl;
	end
endmodule : evt_src
`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none
module testbench
	import evt_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, err;
	logic              clk_en;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, q;
	logic [4:0]        hit, evt;
	logic [FILL_W-1:0] tx_lvl, rx_lvl, tx_fill, rx_fill;
	int                fail_count, cmp_count;
	evt_irq_ctrl u_evt_irq_ctrl (.CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.OVERRUN_EVT(evt[4]), .LINE_BREAK_EVT(evt[3]), .PARITY_FAULT_EVT(evt[2]),
		.FRAME_FAULT_EVT(evt[1]), .RX_TIMEOUT_EVT(evt[0]), .TX_FILL(tx_fill),
		.RX_FILL(rx_fill), .UART_IRQ(irq));
	evt_src u_evt_src (.clk(clk), .hit(hit), .tx_lvl(tx_lvl), .rx_lvl(rx_lvl),
		.evt(evt), .tx_fill(tx_fill), .rx_fill(rx_fill));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic results();
		$display("Compares %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			results();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	task automatic fire(input logic [4:0] h);
		@(posedge clk);
		hit <= h;
		@(posedge clk);
		hit <= 5'h00;
		repeat (3) @(posedge clk);
	endtask : fire
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(OFF_RAW, 32'h0000000F);
		rd(OFF_MASKED, 32'h00000000);
		rd(OFF_CLEAR, 32'h00000000);
		rd(OFF_TRIG_SEL, 32'h00000012);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_events();
		fire(5'h1F);
		rd(OFF_RAW, 32'h000007CF);
		apb(1'b1, OFF_RAW, 32'h00000000);
		apb(1'b1, OFF_MASKED, 32'h000007F0);
		rd(OFF_RAW, 32'h000007CF);
		rd(OFF_MASKED, 32'h00000000);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFF_MASK, 32'h00000280);
		rd(OFF_MASKED, 32'h00000280);
		chk({31'h0, irq}, 32'h1);
		$display("t_events done");
	endtask : t_events
	task automatic t_clear();
		apb(1'b1, OFF_CLEAR, 32'h00000040);
		rd(OFF_RAW, 32'h0000078F);
		apb(1'b1, OFF_CLEAR, 32'h00000280);
		rd(OFF_RAW, 32'h0000050F);
		rd(OFF_MASKED, 32'h00000000);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFF_CLEAR, 32'h000007F0);
		rd(OFF_RAW, 32'h0000000F);
		$display("t_clear done");
	endtask : t_clear
	task automatic t_level();
		rx_lvl <= 5'h07;
		fire(5'h00);
		rd(OFF_RAW, 32'h0000000F);
		rx_lvl <= 5'h08;
		fire(5'h00);
		rd(OFF_RAW, 32'h0000001F);
		apb(1'b1, OFF_CLEAR, 32'h00000010);
		tx_lvl <= 5'h09;
		fire(5'h00);
		rd(OFF_RAW, 32'h0000000F);
		tx_lvl <= 5'h08;
		fire(5'h00);
		rd(OFF_RAW, 32'h0000002F);
		apb(1'b1, OFF_TRIG_SEL, 32'h00000002);
		rd(OFF_TRIG_SEL, 32'h00000002);
		apb(1'b1, OFF_CLEAR, 32'h00000030);
		rx_lvl <= 5'h01;
		fire(5'h00);
		rx_lvl <= 5'h02;
		fire(5'h00);
		rd(OFF_RAW, 32'h0000001F);
		apb(1'b0, 12'h048, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("t_level done");
	endtask : t_level
	task automatic t_freeze();
		clk_en <= 1'b0;
		fire(5'h10);
		clk_en <= 1'b1;
		rd(OFF_RAW, 32'h0000000F);
		$display("t_freeze done");
	endtask : t_freeze
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst_b, psel, penable, pwrite, err} = '0;
		{paddr, pwdata, q, hit, rx_lvl} = '0;
		tx_lvl = 5'h0C;
		clk_en = 1'b1;
		fail_count = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_events();
		t_clear();
		t_freeze();
		t_level();
		results();
	end
endmodule : testbench
`default_nettype wire
